// [src/psb_pkg.sv]
// Constants and types shared by the SOF, test and bring-up block
package psb_pkg;
  localparam logic [4:0] A_CTRL = 5'h00;
  localparam logic [4:0] A_STAT = 5'h01;
  localparam logic [4:0] A_MS   = 5'h09;
  localparam logic [4:0] A_BYP  = 5'h12;
  localparam logic [4:0] A_SOF  = 5'h14;
  localparam logic [4:0] A_EXT1 = 5'h17;
  localparam logic [4:0] A_EXT2 = 5'h18;
  localparam logic [4:0] A_GEN  = 5'h1d;
  localparam logic [4:0] A_PAT  = 5'h1e;
  localparam logic [4:0] A_PAGE = 5'h1f;
  localparam logic [15:0] PG_MAIN = 16'h0000;
  localparam logic [15:0] PG_EXT1 = 16'h0001;
  localparam logic [15:0] PG_EXT2 = 16'h0002;
  localparam logic [15:0] REG_RST = 16'h0000;
  localparam int B_SWRST   = 15;
  localparam int B_NLB     = 14;
  localparam int B_SPD_L   = 13;
  localparam int B_RXOFF   = 10;
  localparam int B_SPD_M   = 6;
  localparam int B_MASTER  = 11;
  localparam int B_XOFF    = 7;
  localparam int B_SWAPOFF = 5;
  localparam int B_MAC_LO  = 11;
  localparam int B_FLB     = 3;
  localparam int B_CONN    = 0;
  localparam int B_LINK    = 2;
  localparam int B_GEN_EN  = 15;
  localparam int B_GEN_RUN = 14;
  localparam int B_GEN_DUR = 13;
  localparam int B_GEN_DA  = 9;
  localparam int B_GEN_SA  = 5;
  localparam int B_GEN_LEN = 4;
  localparam int B_GEN_IFG = 3;
  localparam int B_GEN_FCS = 2;
  localparam int B_SOF_EN  = 12;
  localparam logic [1:0] MAC_RGMII = 2'b10;
  localparam logic [1:0] MAC_RMII  = 2'b01;
  localparam logic [1:0] SPD_1000  = 2'b10;
  localparam logic [1:0] SPD_100   = 2'b01;
  localparam int CLK_NS = 10;
  localparam int MS_NS  = 1_000_000;
  localparam logic [11:0] LU_M1000_MIN = 12'd292;
  localparam logic [11:0] LU_M1000_MAX = 12'd1600;
  localparam logic [11:0] LU_S1000_MIN = 12'd220;
  localparam logic [11:0] LU_S1000_MAX = 12'd1400;
  localparam logic [11:0] LU_100_MIN   = 12'd43;
  localparam logic [11:0] LU_100_MAX   = 12'd240;
  localparam logic [11:0] LU_100X_MAX  = 12'd4000;
  localparam logic [7:0]  SFD      = 8'hd5;
  localparam logic [7:0]  PRE      = 8'h55;
  localparam logic [10:0] PRE_LEN  = 11'd7;
  localparam logic [10:0] ADDR_LEN = 11'd6;
  localparam logic [10:0] LEN_S    = 11'd46;
  localparam logic [10:0] LEN_L    = 11'd1500;
  localparam logic [10:0] FCS_LEN  = 11'd4;
  localparam logic [10:0] IFG_S    = 11'd12;
  localparam logic [10:0] IFG_L    = 11'd1024;
  localparam int GEN_FRAMES = 30_000_000;
  localparam logic [1:0] SOF_STB = 2'd2;
  typedef enum logic [6:0] {
    G_IDLE = 7'h01, G_PRE = 7'h02, G_DA = 7'h04, G_SA = 7'h08,
    G_PAY = 7'h10, G_FCS = 7'h20, G_GAP = 7'h40
  } psb_gen_e;
endpackage

// [src/psb_byte_if.sv]
// Byte stream with its link strobe, shared by the block's modules
`timescale 1ns/1ns
interface psb_byte_if;
  logic       stb;
  logic       en;
  logic [7:0] d;
  modport src (input stb, output en, output d);
  modport snk (input stb, input en, input d);
endinterface // psb_byte_if

// [src/psb_sof_det.sv]
// Frame delimiter detector with start pulse and coding clock copy
`timescale 1ns/1ns
module psb_sof_det
  import psb_pkg::*;
(
  input  wire logic sys_clk, // System clock
  input  wire logic reset,   // Synchronous reset
  psb_byte_if.snk   s,       // Watched byte stream
  output logic      sof,     // Frame start pulse
  output logic      sof_clk  // Coding clock copy
);
  logic       seen_q;
  logic [1:0] cnt_q;
  logic       hit;

  sequence s_sfd;
    s.stb && s.en && (s.d == SFD) && !seen_q;
  endsequence

  // Only the first delimiter of a frame counts
  assign hit = s.stb && s.en && (s.d == SFD) && !seen_q;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      seen_q <= 1'b0;
    end else if (s.stb) begin
      seen_q <= s.en && (seen_q || s.d == SFD);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cnt_q <= 2'h0;
    end else if (hit) begin
      cnt_q <= SOF_STB;
    end else if (s.stb && cnt_q != 2'h0) begin
      cnt_q <= cnt_q - 2'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sof_clk <= 1'b0;
    end else if (s.stb) begin
      sof_clk <= !sof_clk;
    end
  end

  // two strobes span one clock period
  assign sof = (cnt_q != 2'h0);

  a_sof_on_sfd: assert property (
    @(posedge sys_clk) disable iff (reset) s_sfd |=> sof)
    else $error("No start pulse after delimiter");
  a_sof_one_clk: assert property (
    @(posedge sys_clk) disable iff (reset)
    (s.stb && cnt_q == 2'h1 && !hit) |=> !sof)
    else $error("Start pulse longer than one clock");
endmodule // psb_sof_det

// [src/psb_frame_gen.sv]
// Test frame generator driving the twisted-pair transmit stream
`timescale 1ns/1ns
module psb_frame_gen
  import psb_pkg::*;
#(
  parameter int FRAMES = GEN_FRAMES
)(
  input  wire logic        sys_clk, // System clock
  input  wire logic        reset,   // Synchronous reset
  psb_byte_if.src          o,       // Generated stream
  input  wire logic        run,     // Run bit
  input  wire logic        dur,     // Continuous when high
  input  wire logic        len_sel, // Long payload
  input  wire logic        ifg_sel, // Long gap
  input  wire logic        bad_fcs, // Corrupt check bytes
  input  wire logic [3:0]  da,      // Destination nibble
  input  wire logic [3:0]  sa,      // Source nibble
  input  wire logic [15:0] pat,     // Payload pattern
  output logic             done     // Frame quota reached
);
  psb_gen_e    state_q;
  psb_gen_e    nxt;
  logic [10:0] cnt_q;
  logic [10:0] lim;
  logic [24:0] frm_q;
  logic        last;

  always_comb begin
    lim = 11'd0;
    nxt = state_q;
    case (state_q)
      G_IDLE: nxt = run ? G_PRE : G_IDLE;
      G_PRE: begin lim = PRE_LEN; nxt = G_DA; end
      G_DA: begin lim = ADDR_LEN - 11'd1; nxt = G_SA; end
      G_SA: begin lim = ADDR_LEN - 11'd1; nxt = G_PAY; end
      G_PAY: begin
        lim = (len_sel ? LEN_L : LEN_S) - 11'd1;
        nxt = G_FCS;
      end
      G_FCS: begin lim = FCS_LEN - 11'd1; nxt = G_GAP; end
      G_GAP: begin
        lim = (ifg_sel ? IFG_L : IFG_S) - 11'd1;
        nxt = (run && !done) ? G_PRE : G_IDLE;
      end
      default: nxt = G_IDLE;
    endcase
  end
  assign last = (cnt_q == lim);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_q <= G_IDLE;
      cnt_q   <= 11'd0;
    end else if (o.stb) begin
      if (state_q == G_IDLE || last) begin
        state_q <= nxt;
        cnt_q   <= 11'd0;
      end else begin
        cnt_q <= cnt_q + 11'd1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      o.en <= 1'b0;
      o.d  <= 8'h00;
    end else if (o.stb) begin
      o.en <= !(state_q == G_IDLE || state_q == G_GAP);
      case (state_q)
        G_PRE:   o.d <= (cnt_q == PRE_LEN) ? SFD : PRE;
        G_DA:    o.d <= {da, da};
        G_SA:    o.d <= {sa, sa};
        G_PAY:   o.d <= cnt_q[0] ? pat[7:0] : pat[15:8];
        G_FCS:   o.d <= bad_fcs ? 8'hff : 8'h00;
        default: o.d <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset || !run) begin
      frm_q <= 25'd0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (o.stb && state_q == G_FCS && last) begin
        frm_q <= frm_q + 25'd1;
        done  <= !dur && (frm_q == 25'(FRAMES - 1));
      end
    end
  end

  a_gen_done_dur: assert property (
    @(posedge sys_clk) disable iff (reset) done |-> !dur && run)
    else $error("Quota end while continuous");
  a_gen_idle_quiet: assert property (
    @(posedge sys_clk) disable iff (reset)
    (o.stb && state_q == G_IDLE) |=> !o.en)
    else $error("Generator sends while idle");
endmodule // psb_frame_gen

// [src/psb_phy_test.sv]
// PHY start-of-frame pins, forced link-up, test paths and bring-up
// How it works
// - Pulse when frame delimiter octet is seen
// - Pulses and coding clocks for both directions
// - Pulses replace upper receive lines, RGMII/RMII
// - Start pulses only while enable bit set
// - Forced gigabit link-up within master/slave window
// - Forced 100M link-up within its window
// - Bypass bit turns crossover detection off
// - Generator replaces MAC as transmit source
// - Receive-off bit silences MAC receive valid and data while generator enabled; enabled start pulses still drive upper lines
// - Run bit starts frames from generator settings
// - Run bit self-clears after frame quota
// - Far-end loopback echoes media receive data
// - Far-end loopback ignores MAC transmit inputs
// - Near-end loopback returns MAC data, line silent
// - Connector loopback uses normal speed settings
// - MAC interface type held in control field
// - Software reset bit clears itself when done
// - Hold pin keeps device inactive
`timescale 1ns/1ns
module psb_phy_test
  import psb_pkg::*;
#(
  parameter int MS_CYC = MS_NS / CLK_NS,
  parameter int GEN_N  = GEN_FRAMES
)(
  input  wire logic        sys_clk,           // 100 MHz clock
  input  wire logic        reset,             // Sync reset, high
  input  wire logic [4:0]  reg_addr,          // Register address
  input  wire logic [15:0] reg_wdata,         // Write data
  input  wire logic        reg_wr,            // Write strobe
  input  wire logic        reg_rd,            // Read strobe
  output logic      [15:0] reg_rdata,         // Read data
  input  wire logic        hold_inactive_pin, // Keep inactive
  input  wire logic        mdi_clk,           // Line byte clock
  input  wire logic        mdi_energy,        // Partner present
  input  wire logic        mdi_rx_en,         // Line receive valid
  input  wire logic [7:0]  mdi_rxd,           // Line receive byte
  output logic             mdi_tx_en,         // Line send valid
  output logic      [7:0]  mdi_txd,           // Line send byte
  input  wire logic        mac_tx_en,         // MAC send valid
  input  wire logic [7:0]  mac_txd,           // MAC send byte
  output logic             mac_rx_dv,         // MAC receive valid
  output logic      [7:0]  mac_rxd,           // MAC receive byte
  output logic      [1:0]  mac_if_mode,       // MAC interface type
  output logic             link_up,           // Link established
  output logic             auto_x_en,         // Crossover detect
  output logic             pair_swap_en,      // Pair swap fixing
  output logic             conn_loop_1000     // Gigabit plug loop
);
  logic [15:0] page_q;
  logic [15:0] ctrl_q;
  logic [15:0] ms_q;
  logic [15:0] byp_q;
  logic [15:0] ext1_q;
  logic [15:0] ext2_q;
  logic [15:0] gen_q;
  logic [15:0] pat_q;
  logic [15:0] sof_q;
  logic [15:0] rd_d;
  logic        sw_rst;
  logic        wr_main;
  logic        wr_ext1;
  logic        wr_ext2;
  logic        gen_done;
  logic [11:0] sync1_q;
  logic [11:0] sync2_q;
  logic        clk3_q;
  logic        hold_s;
  logic        energy_s;
  logic        rx_en_s;
  logic [7:0]  rxd_s;
  logic        lk_stb;
  logic [1:0]  spd;
  logic [11:0] tgt_min;
  logic [11:0] tgt_max;
  logic        lk_act;
  logic [16:0] div_q;
  logic        ms_tick;
  logic [11:0] ms_cnt_q;
  logic        gen_on;
  logic        near_lb;
  logic        far_lb;
  logic        rx_sof;
  logic        rx_sof_clk;
  logic        tx_sof;
  logic        tx_sof_clk;
  logic        sof_on;
  logic [7:0]  mrxd_q;

  psb_byte_if gen_if ();
  psb_byte_if rx_if ();
  psb_byte_if tx_if ();

  assign sw_rst = ctrl_q[B_SWRST];

  assign wr_main = reg_wr && page_q == PG_MAIN;
  assign wr_ext1 = reg_wr && page_q == PG_EXT1;
  assign wr_ext2 = reg_wr && page_q == PG_EXT2;

  // page select reachable from any page
  always_ff @(posedge sys_clk) begin
    if (reset || sw_rst) begin
      page_q <= REG_RST;
    end else if (reg_wr && reg_addr == A_PAGE) begin
      page_q <= reg_wdata;
    end
  end

  // interface type and main page controls
  always_ff @(posedge sys_clk) begin
    if (reset || sw_rst) begin
      ctrl_q <= REG_RST;
      ms_q   <= REG_RST;
      byp_q  <= REG_RST;
      ext1_q <= REG_RST;
      ext2_q <= REG_RST;
    end else if (wr_main) begin
      case (reg_addr)
        A_CTRL:  ctrl_q <= reg_wdata;
        A_MS:    ms_q   <= reg_wdata;
        A_BYP:   byp_q  <= reg_wdata;
        A_EXT1:  ext1_q <= reg_wdata;
        A_EXT2:  ext2_q <= reg_wdata;
        default: ctrl_q <= ctrl_q;
      endcase
    end
  end

  // hardware clears run unless written now
  always_ff @(posedge sys_clk) begin
    if (reset || sw_rst) begin
      gen_q <= REG_RST;
    end else if (wr_ext1 && reg_addr == A_GEN) begin
      gen_q <= reg_wdata;
    end else if (gen_done) begin
      gen_q[B_GEN_RUN] <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset || sw_rst) begin
      pat_q <= REG_RST;
      sof_q <= REG_RST;
    end else begin
      if (wr_ext1 && reg_addr == A_PAT) begin
        pat_q <= reg_wdata;
      end
      if (wr_ext2 && reg_addr == A_SOF) begin
        sof_q <= reg_wdata;
      end
    end
  end

  always_comb begin
    rd_d = 16'h0000;
    if (reg_addr == A_PAGE) begin
      rd_d = page_q;
    end else begin
      case (page_q)
        PG_MAIN: begin
          case (reg_addr)
            A_CTRL:  rd_d = ctrl_q;
            A_STAT:  rd_d = 16'(link_up) << B_LINK;
            A_MS:    rd_d = ms_q;
            A_BYP:   rd_d = byp_q;
            A_EXT1:  rd_d = ext1_q;
            A_EXT2:  rd_d = ext2_q;
            default: rd_d = 16'h0000;
          endcase
        end
        PG_EXT1: begin
          case (reg_addr)
            A_GEN:   rd_d = gen_q;
            A_PAT:   rd_d = pat_q;
            default: rd_d = 16'h0000;
          endcase
        end
        PG_EXT2: rd_d = (reg_addr == A_SOF) ? sof_q : 16'h0000;
        default: rd_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= reg_rd ? rd_d : 16'h0000;
    end
  end

  // Pins from the line side pass two flops first
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sync1_q <= 12'h000;
      sync2_q <= 12'h000;
      clk3_q  <= 1'b0;
    end else begin
      sync1_q <= {hold_inactive_pin, mdi_energy, mdi_rx_en, mdi_rxd,
                  mdi_clk};
      sync2_q <= sync1_q;
      clk3_q  <= sync2_q[0];
    end
  end
  assign hold_s   = sync2_q[11];
  assign energy_s = sync2_q[10];
  assign rx_en_s  = sync2_q[9];
  assign rxd_s    = sync2_q[8:1];
  assign lk_stb   = sync2_q[0] && !clk3_q;

  // master bit, speed and crossover bypass bit pick the window
  assign spd = {ctrl_q[B_SPD_M], ctrl_q[B_SPD_L]};
  always_comb begin
    tgt_min = LU_100_MIN;
    tgt_max = byp_q[B_XOFF] ? LU_100_MAX : LU_100X_MAX;
    if (spd == SPD_1000) begin
      tgt_min = ms_q[B_MASTER] ? LU_M1000_MIN : LU_S1000_MIN;
      tgt_max = ms_q[B_MASTER] ? LU_M1000_MAX : LU_S1000_MAX;
    end
  end

  assign auto_x_en = (spd == SPD_100) && !byp_q[B_XOFF];

  assign lk_act  = !hold_s && energy_s && !sw_rst;
  assign ms_tick = (div_q == 17'(MS_CYC - 1));
  always_ff @(posedge sys_clk) begin
    if (reset || !lk_act || ms_tick) begin
      div_q <= 17'd0;
    end else begin
      div_q <= div_q + 17'd1;
    end
  end

  // link rises after the least time
  always_ff @(posedge sys_clk) begin
    if (reset || !lk_act) begin
      ms_cnt_q <= 12'd0;
      link_up  <= 1'b0;
    end else begin
      if (ms_tick && !link_up) begin
        ms_cnt_q <= ms_cnt_q + 12'd1;
      end
      link_up <= link_up || (ms_cnt_q == tgt_min);
    end
  end

  assign gen_on  = gen_q[B_GEN_EN];
  assign near_lb = ctrl_q[B_NLB];
  assign far_lb  = ext1_q[B_FLB];

  assign gen_if.stb = lk_stb;
  psb_frame_gen #(
    .FRAMES (GEN_N)
  ) u_gen (
    .sys_clk (sys_clk),
    .reset   (reset || sw_rst),
    .o       (gen_if),
    .run     (gen_on && gen_q[B_GEN_RUN] && !hold_s),
    .dur     (gen_q[B_GEN_DUR]),
    .len_sel (gen_q[B_GEN_LEN]),
    .ifg_sel (gen_q[B_GEN_IFG]),
    .bad_fcs (gen_q[B_GEN_FCS]),
    .da      (gen_q[B_GEN_DA+3:B_GEN_DA]),
    .sa      (gen_q[B_GEN_SA+3:B_GEN_SA]),
    .pat     (pat_q),
    .done    (gen_done)
  );

  always_ff @(posedge sys_clk) begin
    if (reset || hold_s || near_lb) begin
      mdi_tx_en <= 1'b0;
      mdi_txd   <= 8'h00;
    end else if (lk_stb) begin
      if (gen_on) begin
        mdi_tx_en <= gen_if.en;
        mdi_txd   <= gen_if.d;
      end else if (far_lb) begin
        mdi_tx_en <= rx_en_s;
        mdi_txd   <= rxd_s;
      end else begin
        mdi_tx_en <= mac_tx_en;
        mdi_txd   <= mac_txd;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset || hold_s || (gen_on && ctrl_q[B_RXOFF])) begin
      mac_rx_dv <= 1'b0;
      mrxd_q    <= 8'h00;
    end else if (lk_stb) begin
      mac_rx_dv <= near_lb ? mac_tx_en : rx_en_s;
      mrxd_q    <= near_lb ? mac_txd : rxd_s;
    end
  end

  assign rx_if.stb = lk_stb;
  assign rx_if.en  = near_lb ? mac_tx_en : rx_en_s;
  assign rx_if.d   = near_lb ? mac_txd : rxd_s;
  assign tx_if.stb = lk_stb;
  assign tx_if.en  = mdi_tx_en;
  assign tx_if.d   = mdi_txd;

  psb_sof_det u_rx_sof (
    .sys_clk (sys_clk),
    .reset   (reset || sw_rst),
    .s       (rx_if),
    .sof     (rx_sof),
    .sof_clk (rx_sof_clk)
  );
  psb_sof_det u_tx_sof (
    .sys_clk (sys_clk),
    .reset   (reset || sw_rst),
    .s       (tx_if),
    .sof     (tx_sof),
    .sof_clk (tx_sof_clk)
  );

  assign mac_if_mode = ext1_q[B_MAC_LO+1:B_MAC_LO];

  // upper receive lines carry start pulses
  assign sof_on = sof_q[B_SOF_EN] && !hold_s &&
                  (mac_if_mode == MAC_RGMII || mac_if_mode == MAC_RMII);
  assign mac_rxd = sof_on ?
                   {rx_sof, rx_sof_clk, tx_sof, tx_sof_clk, mrxd_q[3:0]} :
                   mrxd_q;

  assign conn_loop_1000 = ext2_q[B_CONN];
  assign pair_swap_en   = !byp_q[B_SWAPOFF];

  sequence s_rst_req;
    !reset && wr_main && reg_addr == A_CTRL && reg_wdata[B_SWRST];
  endsequence

  a_sof_pin_map: assert property (
    @(posedge sys_clk) disable iff (reset)
    sof_on |-> mac_rxd[7] == rx_sof && mac_rxd[5] == tx_sof)
    else $error("Start pulses not on upper lines");
  a_sof_gate_off: assert property (
    @(posedge sys_clk) disable iff (reset)
    !sof_q[B_SOF_EN] |-> mac_rxd == mrxd_q)
    else $error("Start pulses shown while disabled");
  a_link_window: assert property (
    @(posedge sys_clk) disable iff (reset)
    $rose(link_up) |-> ms_cnt_q == tgt_min && ms_cnt_q <= tgt_max)
    else $error("Link rose outside its window");
  a_gen_source: assert property (
    @(posedge sys_clk) disable iff (reset)
    (lk_stb && gen_on && !hold_s && !near_lb) |=>
    mdi_txd == $past(gen_if.d))
    else $error("Line data not from generator");
  a_rx_silenced: assert property (
    @(posedge sys_clk) disable iff (reset)
    (gen_on && ctrl_q[B_RXOFF]) |=> !mac_rx_dv)
    else $error("MAC receive active while disabled");
  a_far_echo: assert property (
    @(posedge sys_clk) disable iff (reset)
    (lk_stb && far_lb && !gen_on && !near_lb && !hold_s) |=>
    mdi_txd == $past(rxd_s) && mdi_tx_en == $past(rx_en_s))
    else $error("Far-end data not echoed");
  a_near_quiet: assert property (
    @(posedge sys_clk) disable iff (reset)
    near_lb |=> !mdi_tx_en)
    else $error("Line sends during near-end loopback");
  a_swrst_clear: assert property (
    @(posedge sys_clk) disable iff (reset)
    s_rst_req ##1 sw_rst |=> !sw_rst && ctrl_q == REG_RST)
    else $error("Software reset did not clear");
  a_page_route: assert property (
    @(posedge sys_clk) disable iff (reset)
    (reg_wr && reg_addr == A_GEN && page_q != PG_EXT1 && !gen_done &&
     !sw_rst) |=> $stable(gen_q))
    else $error("Write reached an unselected page");
  a_hold_idle: assert property (
    @(posedge sys_clk) disable iff (reset)
    hold_s |=> !mdi_tx_en && !link_up)
    else $error("Active while hold pin high");
endmodule // psb_phy_test

// [testbench/psb_line_partner.sv]
// Twisted-pair link partner that sends one test frame on request
`timescale 1ns/1ns
module psb_line_partner (
  output logic       mdi_clk,   // Free-running byte clock
  output logic       mdi_rx_en, // Frame valid
  output logic [7:0] mdi_rxd,   // Frame byte
  input  wire logic  go         // Start a frame
);
  int n;
  initial begin
    mdi_clk = 1'b0;
    mdi_rx_en = 1'b0;
    mdi_rxd = 8'h00;
    n = 0;
    #3;
    forever #80 mdi_clk = ~mdi_clk;
  end
  // Preamble, delimiter, payload; idle data keeps changing
  always @(negedge mdi_clk) begin
    if (go || n != 0) begin
      n <= (n == 23) ? 0 : n + 1;
      mdi_rx_en <= 1'b1;
      mdi_rxd <= (n < 7) ? 8'h55 : (n == 7) ? 8'hd5 : 8'ha6;
    end else begin
      mdi_rx_en <= 1'b0;
      mdi_rxd <= ~mdi_rxd;
    end
  end
endmodule // psb_line_partner

// [testbench/testbench.sv]
// Self-checking bench for the start pulse, test and bring-up block
`timescale 1ns/1ns
module testbench
  import psb_pkg::*;
;
  localparam int MS = 10;
  logic        sys_clk, reset, reg_wr, reg_rd, hold_inactive_pin, go;
  logic        mdi_clk, mdi_energy, mdi_rx_en, mdi_tx_en, mac_tx_en;
  logic        mac_rx_dv, link_up, auto_x_en, pair_swap_en, seen_sfd;
  logic        conn_loop_1000, p;
  logic [1:0]  mac_if_mode;
  logic [4:0]  reg_addr;
  logic [7:0]  mdi_rxd, mdi_txd, mac_txd, mac_rxd;
  logic [15:0] reg_wdata, reg_rdata, rv;
  int          failures = 0;
  int          total_checks = 0;
  int          n;
  psb_phy_test #(.MS_CYC(MS), .GEN_N(3)) dut (.sys_clk, .reset, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .hold_inactive_pin, .mdi_clk,
    .mdi_energy, .mdi_rx_en, .mdi_rxd, .mdi_tx_en, .mdi_txd, .mac_tx_en,
    .mac_txd, .mac_rx_dv, .mac_rxd, .mac_if_mode, .link_up, .auto_x_en,
    .pair_swap_en, .conn_loop_1000);
  psb_line_partner lp (.mdi_clk, .mdi_rx_en, .mdi_rxd, .go);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
    if (mdi_tx_en === 1'b1 && mdi_txd === SFD)
      seen_sfd <= 1'b1;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string m);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge sys_clk);
  endtask
  task automatic frame;
    go <= 1'b1;
    repeat (20) @(posedge sys_clk);
    go <= 1'b0;
    repeat (200) @(posedge sys_clk);
  endtask
  task automatic t_regs;
    rd(A_CTRL, rv);
    chk(rv, REG_RST, "ctrl reset");
    chk({15'h0, pair_swap_en}, 16'h1, "swap reset");
    wr(A_PAGE, PG_EXT2);
    wr(A_SOF, 16'h1000);
    rd(A_SOF, rv);
    chk(rv, 16'h1000, "page 2 reg");
    wr(A_PAGE, PG_MAIN);
    wr(A_GEN, 16'h8000);
    rd(A_SOF, rv);
    chk(rv, 16'h0000, "page 0 hides it");
    rd(5'h05, rv);
    chk(rv, 16'h0000, "unmapped read");
    wr(A_EXT1, 16'h1000);
    chk({14'h0, mac_if_mode}, {14'h0, MAC_RGMII}, "rgmii");
    wr(A_EXT1, 16'h0800);
    chk({14'h0, mac_if_mode}, {14'h0, MAC_RMII}, "rmii");
    wr(A_EXT2, 16'h0001);
    wr(A_BYP, 16'h0020);
    chk({14'h0, conn_loop_1000, pair_swap_en}, 16'h2, "plug");
    wr(A_CTRL, 16'h8000);
    rd(A_CTRL, rv);
    chk(rv, 16'h0000, "reset bit clears");
    chk({14'h0, mac_if_mode}, 16'h0, "regs cleared");
    $display("register test done");
  endtask
  task automatic t_link(input logic [15:0] c, input logic [15:0] m,
                        input int lo);
    mdi_energy <= 1'b0;
    wr(A_CTRL, c);
    wr(A_MS, m);
    mdi_energy <= 1'b1;
    n = 0;
    while (link_up !== 1'b1 && n < 2000 * MS) begin
      @(posedge sys_clk);
      n++;
    end
    chk(16'(n >= lo * MS && n <= lo * MS + MS), 16'h1, "link");
    $display("link test done after %0d cycles", n);
  endtask
  task automatic t_paths;
    chk({15'h0, auto_x_en}, 16'h1, "crossover on");
    wr(A_BYP, 16'h0080);
    chk({15'h0, auto_x_en}, 16'h0, "crossover off");
    hold_inactive_pin <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chk({15'h0, link_up}, 16'h0, "held inactive");
    hold_inactive_pin <= 1'b0;
    wr(A_CTRL, 16'h6000);
    repeat (100) @(posedge sys_clk);
    chk({7'h0, mac_rx_dv, mac_rxd}, 16'h013c, "near rx");
    chk({15'h0, mdi_tx_en}, 16'h0, "near line quiet");
    wr(A_CTRL, 16'h2000);
    wr(A_EXT1, 16'h0008);
    frame();
    chk({7'h0, mdi_tx_en, mdi_txd}, 16'h01a6, "echo");
    chk({8'h0, mac_rxd}, 16'h00a6, "far rx");
    wr(A_EXT1, 16'h0000);
    $display("loopback test done");
  endtask
  task automatic t_gen;
    seen_sfd <= 1'b0;
    wr(A_PAGE, PG_EXT1);
    wr(A_GEN, 16'hc000);
    rv = 16'h4000;
    n = 0;
    while (rv[14] !== 1'b0 && n < 3000) begin
      rd(A_GEN, rv);
      n++;
    end
    chk(rv, 16'h8000, "run clears");
    chk({15'h0, seen_sfd}, 16'h1, "frames sent");
    wr(A_PAGE, PG_MAIN);
    wr(A_CTRL, 16'h2400);
    frame();
    chk({15'h0, mac_rx_dv}, 16'h0, "rx off");
    wr(A_PAGE, PG_EXT1);
    wr(A_GEN, 16'h0000);
    wr(A_PAGE, PG_MAIN);
    $display("generator test done");
  endtask
  task automatic t_sof;
    int w;
    wr(A_CTRL, 16'h2000);
    wr(A_EXT1, 16'h1000);
    wr(A_PAGE, PG_EXT2);
    wr(A_SOF, 16'h1000);
    // Let the earlier frame end so the detector sees an idle byte
    repeat (200) @(posedge sys_clk);
    go <= 1'b1;
    n = 0;
    w = 0;
    p = 1'b0;
    for (int k = 0; k < 500; k++) begin
      @(posedge sys_clk);
      if (k == 20)
        go <= 1'b0;
      if (mac_rxd[7] === 1'b1 && p === 1'b0)
        n++;
      if (mac_rxd[7] === 1'b1)
        w++;
      p = mac_rxd[7];
    end
    chk(16'(n), 16'h1, "one start pulse");
    chk(16'(w), 16'h0020, "pulse spans one clock");
    $display("start pulse test done");
  endtask
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    #300_000;
    failures++;
    wrap_up();
  end
  initial begin
    {reset, reg_wr, reg_rd, hold_inactive_pin, go, mdi_energy} = 6'h21;
    {reg_addr, reg_wdata, mac_tx_en, mac_txd, seen_sfd} = '0;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    mac_tx_en <= 1'b1;
    mac_txd <= 8'h3c;
    repeat (15 * MS) @(posedge sys_clk);
    t_regs();
    t_link(16'h0040, 16'h0800, 292);
    t_link(16'h0040, 16'h0000, 220);
    t_link(16'h2000, 16'h0000, 43);
    t_paths();
    t_gen();
    t_sof();
    wrap_up();
  end
endmodule // testbench
